/* design/mfad_pkg.sv */
// Constants shared by the motion fault alarm detector and its alarm latch.
// Assumes one clock (20 MHz) and a synchronous active-high reset.
// Functional notes
// - Homing with no timing/zero/sensor_input_a signal: alarm 64h
// - Disabled homing signals excluded from that check
// - Limit action 2/3 plus limit input: 66h
// - Soft limit action 2/3, position reached: 67h
// - Torque-off mode 1, either input off: 68h
// - Limit input during homing offset move: 6Ah
// - Homed and mechanism limit reached: 6Dh
// - Bad speed/current, wrap, push request: 70h
// - Gear resolution out of spec: 71h, power-cycle only
// - Alarm drops alarm, motion, ready; stops, de-excites
// - Clear input resets alarm, alarm output returns
package mfad_pkg;
  // ----------------------------------------
  // Alarm codes
  // ----------------------------------------
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_HOME_SIG = 8'h64;
  localparam logic [7:0] CODE_HW_OT = 8'h66;
  localparam logic [7:0] CODE_SW_OT = 8'h67;
  localparam logic [7:0] CODE_STO = 8'h68;
  localparam logic [7:0] CODE_OFFSET = 8'h6A;
  localparam logic [7:0] CODE_MECH_OT = 8'h6D;
  localparam logic [7:0] CODE_OP_DATA = 8'h70;
  localparam logic [7:0] CODE_GEAR = 8'h71;
  // ----------------------------------------
  // Blink counts and setting values
  // ----------------------------------------
  localparam logic [3:0] BLINK_NONE = 4'h0;
  localparam logic [3:0] BLINK_SEVEN = 4'h7;
  localparam logic [3:0] BLINK_ONE = 4'h1;
  localparam logic [1:0] ACT_STOP_ALARM = 2'h2;
  localparam logic [1:0] ACT_DECEL_ALARM = 2'h3;
  localparam logic STO_ALARM_MODE = 1'h1;
  localparam logic DETECT_DISABLED = 1'h0;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [2:0] SYNC_RESET = 3'h7;
endpackage

/* design/mfad_alarm_if.sv */
// Carrier between the detector and its alarm latch.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface mfad_alarm_if;
  logic raise; // A new fault this cycle
  logic [7:0] raiseCode; // Code of that fault
  logic [3:0] raiseBlink; // Blink count of that fault
  logic powerOnly; // Fault clears only by power cycle
  logic clearReq; // Any-reset-class clear request
  logic active; // Alarm latched
  logic [7:0] code; // Latched code
  logic [3:0] blink; // Latched blink count
  modport det (output raise, raiseCode, raiseBlink, powerOnly, clearReq,
    input active, code, blink);
  modport latch (input raise, raiseCode, raiseBlink, powerOnly, clearReq,
    output active, code, blink);
endinterface

/* design/mfad_alarm_latch.sv */
// Holds the first alarm code and its clear class.
// Assumes requests arrive synchronous to clk; power cycle is rst.
`timescale 1ns/1ps
module mfad_alarm_latch (
  input wire logic clk,
  input wire logic rst,
  mfad_alarm_if.latch al
);
  logic powerClass; // Latched alarm needs a power cycle
  // ----------------------------------------
  // Latch process
  // ----------------------------------------
  // First fault wins; a raise in the clear cycle is kept, so set beats clear
  always_ff @(posedge clk) begin
    if (rst) begin
      al.active <= 1'b0;
      al.code <= mfad_pkg::CODE_NONE;
      al.blink <= mfad_pkg::BLINK_NONE;
      powerClass <= 1'b0;
    end else if (al.active && !(al.clearReq && !powerClass)) begin
      // Held; power-class alarms ignore the clear input
    end else if (al.raise) begin
      al.active <= 1'b1;
      al.code <= al.raiseCode;
      al.blink <= al.raiseBlink;
      powerClass <= al.powerOnly;
    end else if (al.active) begin
      al.active <= 1'b0;
      al.code <= mfad_pkg::CODE_NONE;
      al.blink <= mfad_pkg::BLINK_NONE;
    end
  end
  a_power_class_held: assert property (@(posedge clk) disable iff (rst)
    al.active && powerClass |=> al.active && $stable(al.code))
    else $error("power-class alarm cleared");
  a_code_held_latch: assert property (@(posedge clk) disable iff (rst)
    al.active && !al.clearReq |=> $stable(al.code))
    else $error("alarm code changed without clear");
endmodule

/* design/mfad_top.sv */
// Fault detector: conditions sensor, safety and host inputs into alarms.
// Assumes host and settings on clk; pins synchronised here.
`timescale 1ns/1ps
module mfad_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic phase_timing_output, // Pin
  input wire logic encoder_zero_output, // Pin
  input wire logic sensor_input_a, // Pin, sensor_input_a sensor
  input wire logic home_sensor_input, // Pin
  input wire logic forward_limit_input, // Pin
  input wire logic reverse_limit_input, // Pin
  input wire logic safe_torque_off_input_a, // Pin, high = on
  input wire logic safe_torque_off_input_b, // Pin, high = on
  input wire logic alarm_clear_input, // Pin
  input wire logic timZsgDetectEn, // Timing/zero detection enable
  input wire logic slitDetectEn, // Sensor_input_a detection enable
  input wire logic [1:0] limitAction, // Limit input action
  input wire logic [1:0] softLimitAction, // Software limit action
  input wire logic stoMode, // Torque-off mode
  input wire logic homingActive, // Homing run in progress
  input wire logic homingDone, // Homing run finished, one pulse
  input wire logic offsetMoveActive, // Homing offset phase
  input wire logic homeSet, // Home position established
  input wire logic softLimitReached, // Position at software limit
  input wire logic mechLimitReached, // Position at mechanism limit
  input wire logic overSpeedCurrent, // Speed or current over limit
  input wire logic wrapRequest, // Wrap operation requested
  input wire logic wrapEnabled, // Wrap setting enabled
  input wire logic pushRequest, // Push-motion requested
  input wire logic pushSupported, // Actuator supports push
  input wire logic gearOutOfSpec, // Gear resolution out of spec
  input wire logic driveEnable, // Excitation command from host
  input wire logic moveRequest, // Host motion in progress
  output logic alarm_active_low_output,
  output logic drive_command_ready_output,
  output logic motionOutput,
  output logic motorExcite,
  output logic motorStop,
  output logic [7:0] alarmCode,
  output logic [3:0] ledBlinks
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Nine pin inputs share one synchroniser template
  localparam int NPIN = 9;
  logic [NPIN-1:0] pinRaw; // Raw pin levels
  logic [NPIN-1:0] pinStable; // Debounced pin levels
  // Bit order from 0: timing, zero, sensor_input_a, home, limits, torque-off, clear
  assign pinRaw = {alarm_clear_input, safe_torque_off_input_b,
    safe_torque_off_input_a, reverse_limit_input, forward_limit_input,
    home_sensor_input, sensor_input_a, encoder_zero_output,
    phase_timing_output};
  // Three stages; a change counts only when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      logic [2:0] st; // st[0] feeds st[1] only
      // Shift chain; the agreement test filters a single-cycle glitch
      always_ff @(posedge clk) begin
        if (rst) begin
          // Chain and level start low, as if every pin were released
          st <= mfad_pkg::SYNC_RESET & 3'h0;
          pinStable[gi] <= 1'b0;
        end else begin
          st <= {st[1:0], pinRaw[gi]};
          // Level moves only when stages two and three agree
          if (st[1] == st[2]) begin
            pinStable[gi] <= st[2];
          end
        end
      end
    end
  endgenerate
  // Torque-off inputs reset to off would alarm at start; STO treated on level
  wire timSig = pinStable[0];
  wire zsgSig = pinStable[1];
  wire slitSig = pinStable[2];
  // Home sensor level is synchronised only; the host sequences homing runs
  wire fwLimit = pinStable[4];
  wire rvLimit = pinStable[5];
  wire stoA = pinStable[6];
  wire stoB = pinStable[7];
  wire clearPin = pinStable[8];

  // ----------------------------------------
  // Fault decode
  // ----------------------------------------
  // Actions 2 and 3 both stop with alarm; shared by both limit decodes
  function automatic logic alarmAction(input logic [1:0] act);
    alarmAction = (act == mfad_pkg::ACT_STOP_ALARM) || (act == mfad_pkg::ACT_DECEL_ALARM);
  endfunction
  logic homeSigSeen; // Some enabled homing signal seen this run
  wire timChk = (timZsgDetectEn != mfad_pkg::DETECT_DISABLED) && (timSig || zsgSig);
  wire slitChk = (slitDetectEn != mfad_pkg::DETECT_DISABLED) && slitSig;
  wire anyCheckEn = timZsgDetectEn || slitDetectEn;
  wire homeSigFault = homingDone && anyCheckEn && !homeSigSeen && !timChk && !slitChk;
  // Either direction counts for both limit alarms
  wire anyLimit = fwLimit || rvLimit;
  wire hwOtFault = alarmAction(limitAction) && anyLimit;
  wire swOtFault = alarmAction(softLimitAction) && softLimitReached;
  wire stoFault = (stoMode == mfad_pkg::STO_ALARM_MODE) && (!stoA || !stoB);
  wire offsetFault = offsetMoveActive && anyLimit;
  wire mechFault = homeSet && mechLimitReached;
  // Any one of three operation-data faults is enough
  wire opDataFault = overSpeedCurrent || (wrapRequest && !wrapEnabled) ||
    (pushRequest && !pushSupported);
  wire gearFault = gearOutOfSpec;

  // Seen-flag for the homing signal check, cleared at each new run
  always_ff @(posedge clk) begin
    if (rst) begin
      homeSigSeen <= 1'b0;
    end else if (homingActive) begin
      // Sticky while the run lasts; one enabled signal is enough
      homeSigSeen <= homeSigSeen || timChk || slitChk;
    end else begin
      // Idle between runs so a stale sighting never excuses a new run
      homeSigSeen <= 1'b0;
    end
  end

  // ----------------------------------------
  // Alarm latch
  // ----------------------------------------
  mfad_alarm_if al ();
  // Priority: power-class first so a resettable one raised in the same cycle never masks it
  assign al.raise = gearFault || offsetFault || homeSigFault || hwOtFault ||
    swOtFault || stoFault || mechFault || opDataFault;
  assign al.powerOnly = gearFault;
  assign al.raiseCode = gearFault ? mfad_pkg::CODE_GEAR :
    offsetFault ? mfad_pkg::CODE_OFFSET :
    homeSigFault ? mfad_pkg::CODE_HOME_SIG :
    hwOtFault ? mfad_pkg::CODE_HW_OT :
    swOtFault ? mfad_pkg::CODE_SW_OT :
    stoFault ? mfad_pkg::CODE_STO :
    mechFault ? mfad_pkg::CODE_MECH_OT : mfad_pkg::CODE_OP_DATA;
  assign al.raiseBlink = (!gearFault && !offsetFault && !homeSigFault && !hwOtFault &&
    !swOtFault && stoFault) ? mfad_pkg::BLINK_ONE : mfad_pkg::BLINK_SEVEN;
  // Clear passes raw; the latch decides whether its class fits
  assign al.clearReq = clearPin;
  // Latch keeps the first code and its clear class
  mfad_alarm_latch u_latch (
    .clk(clk),
    .rst(rst),
    .al(al)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Registered; one cycle behind the latch
  always_ff @(posedge clk) begin
    if (rst) begin
      // Power-up state: no alarm shown, motor held stopped and unexcited
      alarm_active_low_output <= 1'b1;
      drive_command_ready_output <= 1'b0;
      motionOutput <= 1'b0;
      motorExcite <= 1'b0;
      motorStop <= 1'b1;
      alarmCode <= mfad_pkg::CODE_NONE;
      ledBlinks <= mfad_pkg::BLINK_NONE;
    end else begin
      // Any latched alarm forces the safe state whatever the host asks
      alarm_active_low_output <= !al.active;
      drive_command_ready_output <= !al.active && driveEnable;
      motionOutput <= !al.active && moveRequest;
      motorExcite <= !al.active && driveEnable;
      motorStop <= al.active || !moveRequest;
      alarmCode <= al.code;
      ledBlinks <= al.blink;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Safe state follows the latch by one registered edge
  a_alarm_drops_outputs: assert property (@(posedge clk) disable iff (rst)
    al.active |=> !alarm_active_low_output && !drive_command_ready_output
    && !motionOutput && !motorExcite)
    else $error("outputs not off during alarm");
  // Raise checks: each masks only the faults that outrank it
  a_hw_ot_raises: assert property (@(posedge clk) disable iff (rst)
    !al.active && hwOtFault && !gearFault && !offsetFault && !homeSigFault
    |=> al.code == mfad_pkg::CODE_HW_OT)
    else $error("hardware overtravel not raised");
  a_sw_ot_raises: assert property (@(posedge clk) disable iff (rst)
    !al.active && swOtFault |=> al.active)
    else $error("software overtravel not raised");
  a_sto_one_blink: assert property (@(posedge clk) disable iff (rst)
    al.code == mfad_pkg::CODE_STO |-> al.blink == mfad_pkg::BLINK_ONE)
    else $error("torque-off alarm blink wrong");
  a_offset_raises: assert property (@(posedge clk) disable iff (rst)
    !al.active && offsetFault && !gearFault |=> al.code == mfad_pkg::CODE_OFFSET)
    else $error("offset alarm not raised");
  a_mech_raises: assert property (@(posedge clk) disable iff (rst)
    !al.active && mechFault |=> al.active)
    else $error("mechanical overtravel not raised");
  a_opdata_raises: assert property (@(posedge clk) disable iff (rst)
    !al.active && opDataFault |=> al.active)
    else $error("operation data alarm not raised");
  a_home_sig_check: assert property (@(posedge clk) disable iff (rst)
    !al.active && homeSigFault && !gearFault && !offsetFault
    |=> al.code == mfad_pkg::CODE_HOME_SIG)
    else $error("homing signal alarm not raised");
  a_disabled_no_check: assert property (@(posedge clk) disable iff (rst)
    !timZsgDetectEn && !slitDetectEn |-> !homeSigFault)
    else $error("disabled homing check fired");
  a_gear_raises: assert property (@(posedge clk) disable iff (rst)
    !al.active && gearFault |=> al.active && al.code == mfad_pkg::CODE_GEAR)
    else $error("gear alarm not raised");
  a_sto_raises: assert property (@(posedge clk) disable iff (rst)
    !al.active && stoFault && !gearFault && !offsetFault && !homeSigFault && !hwOtFault
    && !swOtFault |=> al.code == mfad_pkg::CODE_STO)
    else $error("torque-off alarm not raised");
  // Latched pattern: one blink for torque-off, seven for the rest
  a_blink_seven: assert property (@(posedge clk) disable iff (rst)
    al.active && al.code != mfad_pkg::CODE_STO |-> al.blink == mfad_pkg::BLINK_SEVEN)
    else $error("seven-blink pattern wrong");
  // An accepted clear shows on the alarm output two edges later
  a_clear_restores: assert property (@(posedge clk) disable iff (rst)
    al.active && al.code != mfad_pkg::CODE_GEAR && al.clearReq && !al.raise
    |=> ##1 alarm_active_low_output)
    else $error("clear did not restore alarm output");
  // Scenario covers
  c_home_sig: cover property (@(posedge clk) al.code == mfad_pkg::CODE_HOME_SIG);
  c_hw_ot: cover property (@(posedge clk) al.code == mfad_pkg::CODE_HW_OT);
  c_gear: cover property (@(posedge clk) al.code == mfad_pkg::CODE_GEAR);
  c_sto: cover property (@(posedge clk) al.code == mfad_pkg::CODE_STO);
  c_cleared: cover property (@(posedge clk) $fell(al.active));
endmodule

/* testbench/mfad_host_model.sv */
// Far-side model: limit/home/timing sensors, torque-off inputs, host clear handshake.
// Assumes the bench sets sensor levels on the falling edge of clk.
`timescale 1ns/1ps
module mfad_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sens, // Wanted levels: tim,zsg,sensor_input_a,home,fw,rv,stoA,stoB
  input wire logic clearCmd, // Bench asks for one clear handshake
  input wire logic alarmN, // Alarm output seen from the device, low = alarm
  output logic [7:0] pins, // Pin levels toward the device
  output logic clearPin // Alarm clear input toward the device
);
  // ------------------------------------------------
  // Sensors
  // ------------------------------------------------
  // Sensors are push-pull, so a pin simply follows its sensor
  assign pins = sens;
  logic [5:0] cnt; // Cycles since the clear went high
  // ------------------------------------------------
  // Clear handshake
  // ------------------------------------------------
  // Hold clear past the sync delay, drop only once the alarm output is back on;
  // a ceiling stops a refused clear from hanging the run
  always @(posedge clk) begin
    if (rst) begin
      clearPin <= 1'b0;
      cnt <= 6'h00;
    end else if (!clearPin) begin
      clearPin <= clearCmd;
      cnt <= 6'h00;
    end else begin
      cnt <= cnt + 6'h01;
      if ((cnt >= 6'h08 && alarmN) || cnt == 6'h28) clearPin <= 1'b0;
    end
  end
endmodule

/* testbench/motion_fault_alarm_detector_tb_top.sv */
// Self-checking bench for the motion fault alarm detector.
// Assumes mfad_pkg and the host model are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module motion_fault_alarm_detector_tb_top;
  logic clk = 1'b0, rst = 1'b1, clearCmd = 1'b0, clearPin, alarmN, ready, motion, excite, stop;
  logic [7:0] sens = 8'hC0, pins, code; // Torque-off inputs on, all else off
  logic [3:0] blinks;
  logic timEn = 1'b1, slitEn = 1'b1, stoMode = 1'b0, homAct = 1'b0, homDone = 1'b0;
  logic [1:0] limAct = 2'h0, softAct = 2'h0;
  logic offAct = 1'b0, homeSet = 1'b0, softHit = 1'b0, mechHit = 1'b0, overSC = 1'b0;
  logic wrapReq = 1'b0, wrapEn = 1'b1, pushReq = 1'b0, pushSup = 1'b1, gearBad = 1'b0;
  logic drvEn = 1'b1, moveReq = 1'b1;
  int fails = 0, totalChecks = 0, cycles = 0;
  always #25 clk = ~clk; // 20 MHz
  mfad_host_model host (.clk(clk), .rst(rst), .sens(sens), .clearCmd(clearCmd),
    .alarmN(alarmN), .pins(pins), .clearPin(clearPin));
  mfad_top uut (.clk(clk), .rst(rst), .phase_timing_output(pins[0]),
    .encoder_zero_output(pins[1]), .sensor_input_a(pins[2]), .home_sensor_input(pins[3]),
    .forward_limit_input(pins[4]), .reverse_limit_input(pins[5]),
    .safe_torque_off_input_a(pins[6]), .safe_torque_off_input_b(pins[7]),
    .alarm_clear_input(clearPin), .timZsgDetectEn(timEn), .slitDetectEn(slitEn),
    .limitAction(limAct), .softLimitAction(softAct), .stoMode(stoMode),
    .homingActive(homAct), .homingDone(homDone), .offsetMoveActive(offAct),
    .homeSet(homeSet), .softLimitReached(softHit), .mechLimitReached(mechHit),
    .overSpeedCurrent(overSC), .wrapRequest(wrapReq), .wrapEnabled(wrapEn),
    .pushRequest(pushReq), .pushSupported(pushSup), .gearOutOfSpec(gearBad),
    .driveEnable(drvEn), .moveRequest(moveReq), .alarm_active_low_output(alarmN),
    .drive_command_ready_output(ready), .motionOutput(motion), .motorExcite(excite),
    .motorStop(stop), .alarmCode(code), .ledBlinks(blinks));
  // ------------------------------------------------
  // Shared checks
  // ------------------------------------------------
  task automatic test_done();
    if (fails == 0 && totalChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Waits, bounded, for the alarm and checks everything it must shut off
  task automatic expect_alarm(input logic [7:0] c, input logic [3:0] b);
    for (int n = 0; n < 20 && alarmN !== 1'b0; n++) @(negedge clk);
    @(negedge clk);
    `CHK("alarmN", 1'b0, alarmN)
    `CHK("code", c, code)
    `CHK("blinks", b, blinks)
    `CHK("outs", 4'h1, {ready, motion, excite, stop})
  endtask
  // A condition that must not raise anything; then host-idle outputs
  task automatic expect_quiet();
    repeat (12) @(negedge clk);
    `CHK("quiet", 2'h3, {alarmN, ready})
    {drvEn, moveReq} = 2'h0;
    repeat (2) @(negedge clk);
    `CHK("idle", 4'h1, {ready, motion, excite, stop})
    {drvEn, moveReq} = 2'h3;
  endtask
  // Host clear handshake; e = alarm output level expected afterwards
  task automatic clear_alarm(input logic e);
    clearCmd = 1'b1;
    @(negedge clk);
    clearCmd = 1'b0;
    for (int n = 0; n < 60 && clearPin !== 1'b0; n++) @(negedge clk);
    repeat (3) @(negedge clk);
    `CHK("clrN", e, alarmN)
    if (e) `CHK("clrOut", 5'h1C, {ready, motion, excite, stop, |code})
  endtask
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_limits();
    for (int a = 0; a < 4; a++) begin
      limAct = 2'(a);
      sens[4 + a % 2] = 1'b1;
      if (a >= 2) expect_alarm(mfad_pkg::CODE_HW_OT, mfad_pkg::BLINK_SEVEN);
      else expect_quiet();
      sens[5:4] = 2'h0;
      clear_alarm(1'b1);
    end
    offAct = 1'b1; // Offset move outranks plain overtravel
    sens[4] = 1'b1;
    expect_alarm(mfad_pkg::CODE_OFFSET, mfad_pkg::BLINK_SEVEN);
    {offAct, sens[4], limAct} = 4'h0;
    clear_alarm(1'b1);
  endtask
  task automatic t_positions();
    {softAct, softHit, mechHit} = 4'h7; // Action 1 and home not set: silent
    expect_quiet();
    softAct = 2'h3;
    expect_alarm(mfad_pkg::CODE_SW_OT, mfad_pkg::BLINK_SEVEN);
    {softHit, softAct, homeSet} = 4'h1; // Soft limit gone, homed at mechanism limit
    clear_alarm(1'b0); // Mechanism limit still present keeps it
    expect_alarm(mfad_pkg::CODE_MECH_OT, mfad_pkg::BLINK_SEVEN);
    {mechHit, homeSet} = 2'h0;
    clear_alarm(1'b1);
  endtask
  task automatic t_sto_opdata();
    stoMode = 1'b1;
    sens[7] = 1'b0;
    expect_alarm(mfad_pkg::CODE_STO, mfad_pkg::BLINK_ONE);
    sens[7] = 1'b1;
    clear_alarm(1'b1);
    {stoMode, wrapEn, pushSup} = 3'h0;
    for (int i = 0; i < 3; i++) begin
      {overSC, wrapReq, pushReq} = 3'h1 << i;
      expect_alarm(mfad_pkg::CODE_OP_DATA, mfad_pkg::BLINK_SEVEN);
      {overSC, wrapReq, pushReq} = 3'h0;
      clear_alarm(1'b1);
    end
  endtask
  // One homing run; p pulses tim/zsg/sensor_input_a during the run
  task automatic t_home(input logic te, input logic se, input logic [2:0] p, input logic f);
    {timEn, slitEn, homAct} = {te, se, 1'b1};
    repeat (2) @(negedge clk);
    sens[2:0] = p;
    repeat (3) @(negedge clk);
    sens[2:0] = 3'h0;
    repeat (6) @(negedge clk);
    homDone = 1'b1;
    @(negedge clk);
    {homDone, homAct} = 2'h0;
    if (f) expect_alarm(mfad_pkg::CODE_HOME_SIG, mfad_pkg::BLINK_SEVEN);
    else expect_quiet();
    clear_alarm(1'b1);
  endtask
  task automatic t_gear();
    gearBad = 1'b1;
    expect_alarm(mfad_pkg::CODE_GEAR, mfad_pkg::BLINK_SEVEN);
    {gearBad, overSC} = 2'h1; // Later fault must not replace the code
    clear_alarm(1'b0);
    `CHK("kept", mfad_pkg::CODE_GEAR, code)
    overSC = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    `CHK("pwr", 9'h100, {alarmN, code})
  endtask
  // ------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    t_limits();
    t_positions();
    t_sto_opdata();
    t_home(1'b1, 1'b1, 3'h0, 1'b1);
    t_home(1'b0, 1'b0, 3'h0, 1'b0);
    t_home(1'b0, 1'b1, 3'h1, 1'b1);
    t_home(1'b1, 1'b1, 3'h4, 1'b0);
    t_gear();
    test_done();
  end
endmodule
